// ### partition_id_space_virtual_map.sv
// partition identifier and space resolution for memory requests
//
// Functional notes
// - four security states; space and value from cross-level controls.
// - secure-default forces value 0 for non-root secure requests.
// - without alternative selection or force-nonsecure each state keeps its own space.
// - alternative: secure/realm go non-secure, root goes secure or non-secure.
// - alternative space never selected when that feature is absent.
// - virtualization needs enabled hypervisor level and capability flag.
// - kernel capability reads trap when either trap control is set and the hypervisor level is enabled with virtualization.
// - virtual spaces exist only with the virtualization option.
// - partitioning disabled sends the default physical identifier.
// - default space adjusted by force-nonsecure or alternative settings.
// - user and kernel mapping have separate enables.
// - up to eight mapping registers, set by hypervisor software.
// - virtual identifier indexes entries and the matching valid bit.
// - valid entry supplies the physical identifier.
// - out-of-range virtual identifier replaced by an in-range one.
// - invalid entry falls back to the default virtual entry if valid.
// - neither valid: default physical identifier is sent.
// - each mapping register holds four 16-bit identifier fields.
// - one valid bit per implemented mapping entry.
// - kernel mapping enable makes kernel-level identifiers virtual.
//
// Strobed register access and the address map were decided locally.
module partition_id_space_virtual_map
    import partition_map_pkg::*;
#(
    parameter int        VMAP_REGS      = MAX_VMAP_REGS,
    parameter bit        VIRT_IMPL      = 1'b1,
    parameter bit        ALT_IMPL       = 1'b1,
    parameter bit        FORCE_NONSECURE_SPACE_IMPL  = 1'b0,
    parameter logic [15:0] MAX_PART_VALUE = 16'h00FF
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [31:0]       regRdData,
    // request from the core
    input  wire logic              reqValid,
    input  wire logic [1:0]        reqLevel,
    input  wire logic [1:0]        reqSecState,
    input  wire logic              hypEnabled,
    // labelled request to the memory system
    output logic                   outValid,
    output logic      [ID_W-1:0]   outPartitionId,
    output logic      [1:0]        outSpace,
    // capability register read from the core
    input  wire logic              capRead,
    input  wire logic [1:0]        capReadLevel,
    output logic                   capReadTrap
);

    localparam int NUM_ENTRIES = VMAP_REGS * ENTRIES_PER_REG;
    localparam logic [2:0] VMAP_MAX = 3'(VMAP_REGS - 1);
    localparam logic [4:0] MAX_INDEX = 5'(NUM_ENTRIES - 1);

    // ********************************
    // decode helpers
    // ********************************
    function automatic logic isVmapAddr(input logic [ADDR_W-1:0] a);
        return (a >= OFF_VMAP_BASE) && (a <= OFF_VMAP_LAST);
    endfunction

    function automatic logic [4:0] vmapEntry(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] rel;
        rel = a - OFF_VMAP_BASE;
        return {rel[5:2], 1'b0};
    endfunction

    // ********************************
    // control registers
    // ********************************
    logic [31:0]      el3Ctrl_ff;
    logic [31:0]      el2Ctrl_ff;
    logic [ID_W-1:0]  kernCtrl_ff;
    logic [ID_W-1:0]  userCtrl_ff;
    logic [31:0]      hypCtrl_ff;
    logic [NUM_ENTRIES-1:0] validBits_ff;
    logic [ID_W-1:0]  defPhys_ff;
    logic [ID_W-1:0]  vmapMem_ff [NUM_ENTRIES];

    logic partEn;
    logic secDeflt;
    logic forceNs;
    logic rootAlt;
    logic rootAltNs;
    logic lowerAlt;
    logic trapId;
    logic userVmap;
    logic kernVmap;
    logic trapCap;
    logic virtOk;

    assign partEn    = el3Ctrl_ff[BIT_PART_EN];
    assign secDeflt  = el3Ctrl_ff[BIT_SEC_DEFLT];
    assign forceNs   = FORCE_NONSECURE_SPACE_IMPL & el3Ctrl_ff[BIT_FORCE_NONSECURE_SPACE];
    assign rootAlt   = el3Ctrl_ff[BIT_ROOT_ALT];
    assign rootAltNs = el3Ctrl_ff[BIT_ROOT_ALTNS];
    assign lowerAlt  = el2Ctrl_ff[BIT_LOWER_ALT];
    assign trapId    = el2Ctrl_ff[BIT_TRAP_ID];
    assign userVmap  = hypCtrl_ff[BIT_USER_VMAP];
    assign kernVmap  = hypCtrl_ff[BIT_KERN_VMAP];
    assign trapCap   = hypCtrl_ff[BIT_TRAP_CAP];

    // needs the option and an enabled hypervisor level
    assign virtOk = VIRT_IMPL & hypEnabled;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            el3Ctrl_ff  <= RST_CTRL;
            el2Ctrl_ff  <= RST_CTRL;
            kernCtrl_ff <= RST_DEF_PHYS;
            userCtrl_ff <= RST_DEF_PHYS;
            hypCtrl_ff  <= RST_CTRL;
            defPhys_ff  <= RST_DEF_PHYS;
        end else if (regWr) begin
            case (regAddr)
                OFF_EL3_CTRL: begin
                    el3Ctrl_ff <= regWrData;
                end
                OFF_EL2_CTRL: begin
                    el2Ctrl_ff <= regWrData;
                end
                OFF_KERN_CTRL: begin
                    kernCtrl_ff <= regWrData[ID_W-1:0];
                end
                OFF_USER_CTRL: begin
                    userCtrl_ff <= regWrData[ID_W-1:0];
                end
                OFF_HYP_CTRL: begin
                    if (VIRT_IMPL) begin
                        hypCtrl_ff <= regWrData;
                    end
                end
                OFF_DEF_PHYS: begin
                    defPhys_ff <= regWrData[ID_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // valid bits, one per implemented entry
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            validBits_ff <= '0;
        end else if (regWr && regAddr == OFF_VALID && VIRT_IMPL) begin
            validBits_ff <= regWrData[NUM_ENTRIES-1:0];
        end
    end

    // ********************************
    // mapping entries, two per word
    // ********************************
    genvar g;
    generate
        for (g = 0; g < NUM_ENTRIES; g++) begin : gEntry
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    vmapMem_ff[g] <= RST_DEF_PHYS;
                end else if (regWr && VIRT_IMPL && isVmapAddr(regAddr)
                             && vmapEntry(regAddr) == 5'(g & ~1)) begin
                    vmapMem_ff[g] <= regWrData[(g%2)*ID_W +: ID_W];
                end
            end
        end
    endgenerate

    // ********************************
    // space selection
    // ********************************
    logic   altSel;
    space_t nxtSpace;
    logic [ID_W-1:0] srcId;
    logic            virtualize;
    logic [ID_W-1:0] nxt_partitionId;

    always_comb begin
        // alternative space needs the feature
        altSel = ALT_IMPL
               & ((reqLevel == LVL_ROOT) ? rootAlt : lowerAlt);
        case (space_t'(reqSecState))
            SP_ROOT: begin
                if (altSel) begin
                    nxtSpace = rootAltNs ? SP_NONSEC : SP_SECURE;
                end else begin
                    nxtSpace = SP_ROOT;
                end
            end
            SP_SECURE: begin
                if (altSel || forceNs) begin
                    nxtSpace = SP_NONSEC;
                end else begin
                    nxtSpace = SP_SECURE;
                end
            end
            SP_REALM: begin
                nxtSpace = altSel ? SP_NONSEC : SP_REALM;
            end
            default: begin
                nxtSpace = SP_NONSEC;
            end
        endcase
    end

    // ********************************
    // identifier source and mapping
    // ********************************
    vmap_if #(.ID_W(ID_W), .NUM_ENTRIES(NUM_ENTRIES)) vmBus ();

    always_comb begin
        vmBus.validBits   = validBits_ff;
        vmBus.maxIndex    = MAX_INDEX;
        vmBus.defaultPhys = defPhys_ff;
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            vmBus.entryFlat[i*ID_W +: ID_W] = vmapMem_ff[i];
        end
    end

    always_comb begin
        case (level_t'(reqLevel))
            LVL_ROOT: begin
                srcId      = el3Ctrl_ff[POS_EL3_ID +: ID_W];
                virtualize = 1'b0;
            end
            LVL_HYP: begin
                srcId      = el2Ctrl_ff[ID_W-1:0];
                virtualize = 1'b0;
            end
            LVL_KERNEL: begin
                srcId      = kernCtrl_ff;
                virtualize = virtOk & kernVmap;
            end
            default: begin
                srcId      = userCtrl_ff;
                virtualize = virtOk & userVmap;
            end
        endcase
        vmBus.virtId = srcId[4:0];
    end

    vmap_lookup #(
        .NUM_ENTRIES (NUM_ENTRIES)
    ) uLookup (
        .vm (vmBus.lookup)
    );

    // final value ahead of the output stage
    always_comb begin
        if (!partEn) begin
            nxt_partitionId = defPhys_ff;
        end else if (secDeflt && reqSecState == SP_SECURE
                     && reqLevel != LVL_ROOT) begin
            nxt_partitionId = SEC_DEFAULT_ID;
        end else if (virtualize) begin
            nxt_partitionId = vmBus.physId;
        end else begin
            nxt_partitionId = srcId;
        end
    end

    // ********************************
    // output stage
    // ********************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            outValid       <= 1'b0;
            outPartitionId <= RST_DEF_PHYS;
            outSpace       <= SP_SECURE;
        end else begin
            outValid <= reqValid;
            if (reqValid) begin
                outPartitionId <= nxt_partitionId;
                outSpace       <= nxtSpace;
            end
        end
    end

    // trapped kernel capability reads
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            capReadTrap <= 1'b0;
        end else begin
            capReadTrap <= capRead && virtOk
                         && capReadLevel == LVL_KERNEL
                         && (trapCap || trapId);
        end
    end

    // ********************************
    // register read back
    // ********************************
    logic [31:0] capWord;
    logic [31:0] nxt_rdData;
    logic [4:0]  rdEntry;

    always_comb begin
        capWord = '0;
        capWord[ID_W-1:0]          = MAX_PART_VALUE;
        capWord[POS_CAP_VMAX +: 3] = VMAP_MAX;
        capWord[BIT_CAP_VIRT]      = VIRT_IMPL;
        capWord[BIT_CAP_FNS]       = FORCE_NONSECURE_SPACE_IMPL;
        capWord[BIT_CAP_ALT]       = ALT_IMPL;
        rdEntry = vmapEntry(regAddr);
        nxt_rdData = '0;
        if (isVmapAddr(regAddr)) begin
            if (int'(rdEntry) < NUM_ENTRIES) begin
                nxt_rdData = {vmapMem_ff[rdEntry + 5'h01],
                              vmapMem_ff[rdEntry]};
            end
        end else begin
            case (regAddr)
                OFF_EL3_CTRL:   nxt_rdData = el3Ctrl_ff;
                OFF_EL2_CTRL:   nxt_rdData = el2Ctrl_ff;
                OFF_KERN_CTRL:  nxt_rdData = 32'(kernCtrl_ff);
                OFF_USER_CTRL:  nxt_rdData = 32'(userCtrl_ff);
                OFF_HYP_CTRL:   nxt_rdData = hypCtrl_ff;
                OFF_VALID:      nxt_rdData = 32'(validBits_ff);
                OFF_DEF_PHYS:   nxt_rdData = 32'(defPhys_ff);
                OFF_CAPABILITY: nxt_rdData = capWord;
                OFF_STATUS: begin
                    nxt_rdData[ID_W-1:0]             = outPartitionId;
                    nxt_rdData[POS_STAT_SPACE +: 2]  = outSpace;
                    nxt_rdData[BIT_STAT_TRAP]        = capReadTrap;
                end
                default:        nxt_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= nxt_rdData;
        end else begin
            regRdData <= '0;
        end
    end

endmodule // partition_id_space_virtual_map

// ### partition_map_pkg.sv
// constants and types shared by the partition identifier mapping block
package partition_map_pkg;

    // ********************************
    // widths and implementation sizes
    // ********************************
    localparam int ID_W          = 16;
    localparam int MAX_VMAP_REGS = 8;
    localparam int ENTRIES_PER_REG = 4;
    localparam int ADDR_W        = 8;

    // ********************************
    // register byte offsets
    // ********************************
    localparam logic [7:0] OFF_EL3_CTRL   = 8'h00;
    localparam logic [7:0] OFF_EL2_CTRL   = 8'h04;
    localparam logic [7:0] OFF_KERN_CTRL  = 8'h08;
    localparam logic [7:0] OFF_USER_CTRL  = 8'h0C;
    localparam logic [7:0] OFF_HYP_CTRL   = 8'h10;
    localparam logic [7:0] OFF_VALID      = 8'h14;
    localparam logic [7:0] OFF_DEF_PHYS   = 8'h18;
    localparam logic [7:0] OFF_VMAP_BASE  = 8'h40;
    localparam logic [7:0] OFF_VMAP_LAST  = 8'h7C;
    localparam logic [7:0] OFF_CAPABILITY = 8'h80;
    localparam logic [7:0] OFF_STATUS     = 8'h84;

    // ********************************
    // field positions
    // ********************************
    localparam int BIT_PART_EN    = 0;
    localparam int BIT_SEC_DEFLT  = 1;
    localparam int BIT_FORCE_NONSECURE_SPACE   = 2;
    localparam int BIT_ROOT_ALT   = 3;
    localparam int BIT_ROOT_ALTNS = 4;
    localparam int POS_EL3_ID     = 16;
    localparam int BIT_LOWER_ALT  = 16;
    localparam int BIT_TRAP_ID    = 17;
    localparam int BIT_USER_VMAP  = 0;
    localparam int BIT_KERN_VMAP  = 1;
    localparam int BIT_TRAP_CAP   = 8;
    localparam int POS_CAP_VMAX   = 16;
    localparam int BIT_CAP_VIRT   = 19;
    localparam int BIT_CAP_FNS    = 20;
    localparam int BIT_CAP_ALT    = 21;
    localparam int POS_STAT_SPACE = 16;
    localparam int BIT_STAT_TRAP  = 18;

    // ********************************
    // reset and fixed values
    // ********************************
    localparam logic [31:0]     RST_CTRL        = 32'h0000_0000;
    localparam logic [ID_W-1:0] SEC_DEFAULT_ID  = 16'h0000;
    localparam logic [ID_W-1:0] RST_DEF_PHYS    = 16'h0000;
    localparam logic [4:0]      DEFAULT_VIRT_ID = 5'h00;

    // ********************************
    // enumerations
    // ********************************
    typedef enum logic [1:0] {
        SP_SECURE = 2'b00,
        SP_NONSEC = 2'b01,
        SP_ROOT   = 2'b10,
        SP_REALM  = 2'b11
    } space_t;

    typedef enum logic [1:0] {
        LVL_USER   = 2'b00,
        LVL_KERNEL = 2'b01,
        LVL_HYP    = 2'b10,
        LVL_ROOT   = 2'b11
    } level_t;

endpackage

// ### vmap_if.sv
// carrier between the resolver and the virtual map lookup
interface vmap_if #(
    parameter int ID_W        = 16,
    parameter int NUM_ENTRIES = 32
);
    logic [NUM_ENTRIES*ID_W-1:0] entryFlat;
    logic [NUM_ENTRIES-1:0]      validBits;
    logic [4:0]                  virtId;
    logic [4:0]                  maxIndex;
    logic [ID_W-1:0]             defaultPhys;
    logic [ID_W-1:0]             physId;

    modport requester (
        output entryFlat, validBits, virtId, maxIndex, defaultPhys,
        input  physId
    );
    modport lookup (
        input  entryFlat, validBits, virtId, maxIndex, defaultPhys,
        output physId
    );
endinterface

// ### vmap_lookup.sv
// virtual to physical identifier translation with fallbacks
module vmap_lookup
    import partition_map_pkg::*;
#(
    parameter int NUM_ENTRIES = 32
) (
    // map tables and query
    vmap_if.lookup vm
);

    logic [4:0]      index;
    logic [ID_W-1:0] hitEntry;
    logic [ID_W-1:0] defEntry;

    // ********************************
    // in-range replacement and select
    // ********************************
    always_comb begin
        index = (vm.virtId > vm.maxIndex) ? vm.maxIndex : vm.virtId;
        hitEntry = vm.entryFlat[index*ID_W +: ID_W];
        defEntry = vm.entryFlat[DEFAULT_VIRT_ID*ID_W +: ID_W];
        if (vm.validBits[index]) begin
            vm.physId = hitEntry;
        end else if (vm.validBits[DEFAULT_VIRT_ID]) begin
            vm.physId = defEntry;
        end else begin
            vm.physId = vm.defaultPhys;
        end
    end

endmodule // vmap_lookup

// ### partition_map_props.sv
// port-level assertions for the partition identifier block
module partition_map_props
    import partition_map_pkg::*;
#(
    parameter bit VIRT_IMPL = 1'b1
) (
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              rst_b,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0]       regWrData,
    input wire logic              regWr,
    input wire logic              regRd,
    input wire logic [31:0]       regRdData,
    // request path
    input wire logic              reqValid,
    input wire logic [1:0]        reqLevel,
    input wire logic [1:0]        reqSecState,
    input wire logic              outValid,
    input wire logic [ID_W-1:0]   outPartitionId,
    input wire logic [1:0]        outSpace,
    // capability trap
    input wire logic              capRead,
    input wire logic [1:0]        capReadLevel,
    input wire logic              capReadTrap
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************
    // shadow of the space controls
    // ****************
    logic [31:0] rootCtrl_ff;
    logic [31:0] el2Ctrl_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            rootCtrl_ff <= RST_CTRL;
        else if (regWr && regAddr == OFF_EL3_CTRL)
            rootCtrl_ff <= regWrData;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            el2Ctrl_ff <= RST_CTRL;
        else if (regWr && regAddr == OFF_EL2_CTRL)
            el2Ctrl_ff <= regWrData;
    end

    // ****************
    // properties
    // ****************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_valid_follows: assert property (reqValid |=> outValid)
        else $error("request not labelled one cycle later");
    chk_no_extra_valid: assert property (!reqValid |=> !outValid)
        else $error("label without request");
    chk_label_holds: assert property (!reqValid |=>
        $stable(outPartitionId) && $stable(outSpace))
        else $error("label changed without request");
    chk_rd_idle_zero: assert property (!regRd |=> regRdData == 32'h0)
        else $error("read data outside read cycle");
    chk_cap_virt_flag: assert property (regRd &&
        regAddr == OFF_CAPABILITY |=> regRdData[BIT_CAP_VIRT] == VIRT_IMPL)
        else $error("virtualization flag wrong");
    chk_trap_level: assert property (capRead &&
        capReadLevel != LVL_KERNEL |=> !capReadTrap)
        else $error("trap for non-kernel read");
    chk_trap_source: assert property (!capRead |=> !capReadTrap)
        else $error("trap without read");
    chk_sec_default: assert property (reqValid &&
        reqSecState == SP_SECURE && reqLevel != LVL_ROOT &&
        rootCtrl_ff[BIT_PART_EN] && rootCtrl_ff[BIT_SEC_DEFLT]
        |=> outPartitionId == SEC_DEFAULT_ID)
        else $error("secure default value not forced");
    chk_alt_nonsec: assert property (reqValid &&
        reqLevel != LVL_ROOT && reqSecState != SP_ROOT &&
        el2Ctrl_ff[BIT_LOWER_ALT] |=> outSpace == SP_NONSEC)
        else $error("alternative space not non-secure");
    chk_own_space: assert property (reqValid &&
        reqLevel != LVL_ROOT && reqSecState != SP_ROOT &&
        !el2Ctrl_ff[BIT_LOWER_ALT] |=> outSpace == $past(reqSecState))
        else $error("primary space wrong");
    chk_root_space: assert property (reqValid &&
        reqLevel == LVL_ROOT && !rootCtrl_ff[BIT_ROOT_ALT]
        |=> outSpace == SP_ROOT)
        else $error("root space wrong");
endmodule // partition_map_props

// ### mem_request_sink.sv
// memory system side that accepts every labelled request
module mem_request_sink
    import partition_map_pkg::*;
(
    // clock and reset
    input wire logic            sys_clk,
    input wire logic            rst_b,
    // labelled request
    input wire logic            outValid,
    input wire logic [ID_W-1:0] outPartitionId,
    input wire logic [1:0]      outSpace,
    // accepted count
    output logic [31:0]         reqCount_ff
);
    timeunit 1ns;
    timeprecision 100ps;

    // never stalls: the request path has no back-pressure
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            reqCount_ff <= 32'h0;
        else if (outValid)
            reqCount_ff <= reqCount_ff + 32'h1;
    end
endmodule // mem_request_sink

// ### tb_top.sv
// self-checking bench for the partition identifier block
module tb_top;
    import partition_map_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************
    // signals and reference state
    // ****************
    logic              sys_clk      = 1'b0;
    logic              rst_b        = 1'b0;
    logic [ADDR_W-1:0] regAddr      = 8'h00;
    logic [31:0]       regWrData    = 32'h0;
    logic              regWr        = 1'b0;
    logic              regRd        = 1'b0;
    logic              reqValid     = 1'b0;
    logic [1:0]        reqLevel     = 2'h0;
    logic [1:0]        reqSecState  = 2'h0;
    logic              hypEnabled   = 1'b0;
    logic              capRead      = 1'b0;
    logic [1:0]        capReadLevel = 2'h0;
    logic [31:0]       regRdData, sinkCount;
    logic              outValid, capReadTrap;
    logic [ID_W-1:0]   outPartitionId;
    logic [1:0]        outSpace;
    logic [31:0]       mRoot, mEl2, mKern, mUser, mHyp, mDef, mValid, q;
    logic [15:0]       mMap [32];
    int                n_fail  = 0;
    int                n_tests = 0;
    int                nReq    = 0;
    integer            seed    = 32'h13349760;

    localparam logic [31:0] CAP_EXP = {10'h000, 3'b101, 3'h7, 16'h00FF};

    partition_id_space_virtual_map i_dut (
        .sys_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .reqValid, .reqLevel, .reqSecState, .hypEnabled, .outValid,
        .outPartitionId, .outSpace, .capRead, .capReadLevel, .capReadTrap);

    mem_request_sink i_sink (
        .sys_clk, .rst_b, .outValid, .outPartitionId, .outSpace,
        .reqCount_ff(sinkCount));

    always #12.5 sys_clk = ~sys_clk;

    // ****************
    // helpers
    // ****************
    function automatic logic [15:0] rnd16();
        return 16'($random(seed)) & 16'h00FF;
    endfunction

    function automatic logic [17:0] predict(logic [1:0] l, s, logic h);
        logic [1:0]  sp;
        logic [15:0] id;
        sp = s;
        if (l == LVL_ROOT)
            sp = !mRoot[3] ? SP_ROOT : (mRoot[4] ? SP_NONSEC : SP_SECURE);
        else if (mEl2[16])
            sp = SP_NONSEC;
        id = (l == LVL_ROOT) ? mRoot[31:16] : (l == LVL_HYP) ? mEl2[15:0] :
             (l == LVL_KERNEL) ? mKern[15:0] : mUser[15:0];
        if (h && ((l == LVL_USER && mHyp[0]) || (l == LVL_KERNEL && mHyp[1])))
            id = mValid[id[4:0]] ? mMap[id[4:0]] :
                 (mValid[0] ? mMap[0] : mDef[15:0]);
        if (!mRoot[0])
            id = mDef[15:0];
        else if (s == SP_SECURE && l != LVL_ROOT && mRoot[1])
            id = SEC_DEFAULT_ID;
        return {sp, id};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
        case (a)
            OFF_EL3_CTRL:  mRoot = d;
            OFF_EL2_CTRL:  mEl2 = d;
            OFF_KERN_CTRL: mKern = d;
            OFF_USER_CTRL: mUser = d;
            OFF_HYP_CTRL:  mHyp = d;
            OFF_VALID:     mValid = d;
            OFF_DEF_PHYS:  mDef = d;
            default: begin
                if (a >= OFF_VMAP_BASE && a <= OFF_VMAP_LAST)
                    {mMap[{a[5:2], 1'b1}], mMap[{a[5:2], 1'b0}]} = d;
            end
        endcase
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask

    task automatic req(input logic [1:0] l, s, input logic h);
        logic [17:0] e;
        e = predict(l, s, h);
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqLevel <= l;
        reqSecState <= s;
        hypEnabled <= h;
        @(posedge sys_clk);
        reqValid <= 1'b0;
        #1 check({13'h0, outValid, outSpace, outPartitionId}, {14'h1, e});
        nReq++;
    endtask

    task automatic stop_test();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    initial begin
        logic [1:0] l;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), q);
            check(q, 32'h0);
        end
        rd(OFF_CAPABILITY, q);
        check(q, CAP_EXP);
        wr(OFF_CAPABILITY, 32'hFFFFFFFF);
        rd(OFF_CAPABILITY, q);
        check(q, CAP_EXP);
        wr(OFF_VALID, 32'hFFFFFFFF);
        rd(OFF_VALID, q);
        check(q, mValid);
        wr(OFF_DEF_PHYS, {16'h0, rnd16()});
        wr(OFF_KERN_CTRL, {16'h0, rnd16()});
        wr(OFF_USER_CTRL, {16'h0, rnd16()});
        for (int c = 0; c < 32; c++) begin
            wr(OFF_EL3_CTRL, {rnd16(), 11'h0, c[4:3], 1'b0, c[1:0]});
            wr(OFF_EL2_CTRL, {15'h0, c[2], rnd16()});
            for (int a = 0; a < 4; a++)
                for (int s = 0; s < 4; s++)
                    if ((a == 3) == (s == 2))
                        req(2'(a), 2'(s), 1'b0);
        end
        for (int k = 0; k < 16; k++)
            wr(OFF_VMAP_BASE + 8'(4 * k), {rnd16(), rnd16()});
        rd(OFF_VMAP_BASE + 8'h04, q);
        check(q, {mMap[3], mMap[2]});
        wr(OFF_EL3_CTRL, 32'h1);
        wr(OFF_EL2_CTRL, {16'h0, rnd16()});
        for (int i = 0; i < 60; i++) begin
            wr(OFF_HYP_CTRL, {30'h0, 2'($random(seed))});
            wr(OFF_VALID, (i % 4 == 1) ? 32'h0 :
                          (i % 4 == 2) ? 32'h1 : 32'($random(seed)));
            wr(OFF_USER_CTRL, {16'h0, rnd16()});
            wr(OFF_KERN_CTRL, {16'h0, rnd16()});
            l = 2'($random(seed));
            if (l == LVL_ROOT)
                l = LVL_KERNEL;
            req(l, (i % 2) ? SP_NONSEC : SP_REALM,
                1'($random(seed)));
        end
        for (int c = 0; c < 32; c++) begin
            wr(OFF_HYP_CTRL, {23'h0, c[0], 8'h00});
            wr(OFF_EL2_CTRL, {14'h0, c[1], 17'h0});
            @(posedge sys_clk);
            capRead <= 1'b1;
            capReadLevel <= c[4:3];
            hypEnabled <= c[2];
            @(posedge sys_clk);
            capRead <= 1'b0;
            #1 check({31'h0, capReadTrap},
                     {31'h0, c[4:3] == 2'h1 && c[2] && |c[1:0]});
        end
        check(sinkCount, 32'(nReq));
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(posedge sys_clk);
        #1 check({13'h0, outValid, outSpace, outPartitionId}, 32'h0);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFF_EL3_CTRL, q);
        check(q, RST_CTRL);
        stop_test();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        n_fail++;
        stop_test();
    end
endmodule // tb_top

bind partition_id_space_virtual_map partition_map_props #(
    .VIRT_IMPL(VIRT_IMPL)
) i_props (
    .sys_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .reqValid, .reqLevel, .reqSecState, .outValid, .outPartitionId,
    .outSpace, .capRead, .capReadLevel, .capReadTrap
);
